// >>> rtl/dbc_pkg.sv
// dbc_pkg: constants and types for the dram bank command state logic
// assumes a 100 MHz command clock; timing figures in ns or cycles
package dbc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NUM_BANKS = 4;
  localparam int unsigned BANK_W = 2;
  // interval figures in ns
  localparam int unsigned PRECHARGE_TIME_NS = 20;
  localparam int unsigned ACTIVATE_TO_ACCESS_TIME_NS = 20;
  localparam int unsigned REFRESH_CYCLE_TIME_NS = 80;
  localparam int unsigned MODE_SET_TIME_NS = 20;
  localparam int unsigned SELF_REFRESH_EXIT_TIME_NS = 80;
  // least times round up to whole cycles
  localparam int unsigned PRECHARGE_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACT_CYC =
    (ACTIVATE_TO_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_CYC =
    (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MODE_SET_CYC = (MODE_SET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SR_EXIT_CYC =
    (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BURST_CYC = 4;
  localparam int unsigned TMR_W = 8;
  localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;
  localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;
  localparam logic [BANK_W-1:0] BANK_ZERO = 2'h0;
  localparam int unsigned AP_BIT = 10;
  // command codes: {select_n, row_strobe_n, column_strobe_n, write_enable_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_BST = 4'h6;
  // per-bank states
  typedef enum logic [3:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
    BK_READ_AP, BK_WRITE_AP, BK_PRECHARGING
  } dbc_bank_state_t;
  // device-wide states
  typedef enum logic [2:0] {
    DV_NORMAL, DV_REFRESHING, DV_MODE_SET, DV_PRECHARGE_PD, DV_ACTIVE_PD,
    DV_SELF_REFRESH, DV_SR_EXIT
  } dbc_dev_state_t;
endpackage : dbc_pkg

// >>> rtl/dbc_bank.sv
// dbc_bank: state and timer of one bank
// assumes commands are already decoded and qualified by the device logic
`timescale 1ns/10ps
module dbc_bank
  import dbc_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic act_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic pre_i,
  input wire logic stop_i,
  input wire logic auto_pre_i,
  output dbc_bank_state_t state_o
);
  dbc_bank_state_t state_q, state_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  wire logic expired = (tmr_q <= TMR_ONE);
  wire logic [TMR_W-1:0] tmr_dec = expired ? TMR_ZERO : tmr_q - TMR_ONE;
  // ************************************
  // next state
  // ************************************
  always_comb begin
    state_d = state_q;
    tmr_d = tmr_dec;
    unique case (state_q)
      BK_IDLE: begin
        if (act_i) begin
          state_d = BK_ACTIVATING;
          tmr_d = TMR_W'(ACT_CYC);
        end
      end
      BK_ACTIVATING: begin
        if (expired) state_d = BK_ACTIVE;
      end
      BK_ACTIVE, BK_READ, BK_WRITE: begin
        if (pre_i) begin
          state_d = BK_PRECHARGING;
          tmr_d = TMR_W'(PRECHARGE_CYC);
        end else if (read_i) begin
          state_d = auto_pre_i ? BK_READ_AP : BK_READ;
          tmr_d = TMR_W'(auto_pre_i ? BURST_CYC + PRECHARGE_CYC : BURST_CYC);
        end else if (write_i && state_q != BK_READ) begin
          state_d = auto_pre_i ? BK_WRITE_AP : BK_WRITE;
          tmr_d = TMR_W'(auto_pre_i ? BURST_CYC + PRECHARGE_CYC : BURST_CYC);
        end else if (stop_i && state_q == BK_READ) begin
          state_d = BK_ACTIVE;
        end else if (state_q != BK_ACTIVE && expired) begin
          state_d = BK_ACTIVE;
        end
      end
      BK_READ_AP, BK_WRITE_AP: begin
        if (expired) state_d = BK_IDLE;
      end
      BK_PRECHARGING: begin
        if (expired) state_d = BK_IDLE;
      end
      default: state_d = BK_IDLE;
    endcase
  end
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_q <= BK_IDLE;
      tmr_q <= TMR_ZERO;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
    end
  end
  assign state_o = state_q;
endmodule : dbc_bank

// >>> rtl/dbc_top.sv
// dbc_top: command decoder and state logic of a quad-bank ddr dram
// assumes the controller keeps its rules; commands sampled at each rising clock edge
// Function
// - act on previous and current clock enable plus current command
// - same-bank decoding only with enable high twice and self-refresh exit done
// - deselect and nop continue any operation in progress
// - activate opens a row in an idle bank
// - auto refresh and mode set only with all banks idle
// - read starts a read burst from row active or write burst
// - write starts a write burst from a row-active bank
// - precharge closes the open row of the selected bank or banks
// - read during read burst restarts a new read burst
// - precharge during read burst truncates it and precharges
// - burst terminate stops the most recent read burst, any bank
// - read or precharge truncates a write burst; controller masks data
// - idle after precharge time, active after activate-to-access time
// - auto-precharge access holds the bank for burst plus precharge time, then idle
// - refresh and mode set last their times, then all banks idle
// - unlisted state and command pairs are illegal; response undefined
// - reads and writes accept both auto-precharge forms
// - enable low with nop enters precharge or active power-down
// - enable high with nop exits power-down
`timescale 1ns/10ps
module dbc_top
  import dbc_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clock_enable_i,
  input wire logic chip_select_n_i,
  input wire logic row_strobe_n_i,
  input wire logic column_strobe_n_i,
  input wire logic write_enable_n_i,
  input wire logic [BANK_W-1:0] bank_addr_i,
  input wire logic auto_pre_i,
  output dbc_dev_state_t dev_state_o,
  output logic [NUM_BANKS-1:0] bank_idle_o,
  output logic [NUM_BANKS-1:0] bank_open_o,
  output logic cmd_ready_o
);
  // ************************************
  // command decode
  // ************************************
  logic cke_prev_q;
  dbc_dev_state_t dev_q, dev_d;
  logic [TMR_W-1:0] dtmr_q, dtmr_d;
  dbc_bank_state_t bank_st [NUM_BANKS];
  logic [BANK_W-1:0] last_read_bank_q;
  logic last_read_valid_q;
  wire logic [3:0] cmd = {chip_select_n_i, row_strobe_n_i, column_strobe_n_i,
    write_enable_n_i};
  wire logic is_nop = chip_select_n_i || (cmd == CMD_NOP);
  wire logic cke_hh = cke_prev_q && clock_enable_i;
  wire logic cke_hl = cke_prev_q && !clock_enable_i;
  wire logic cke_lh = !cke_prev_q && clock_enable_i;
  wire logic dev_expired = (dtmr_q <= TMR_ONE);
  logic all_idle;
  logic any_open;
  always_comb begin
    all_idle = 1'b1;
    any_open = 1'b0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (bank_st[i] != BK_IDLE) all_idle = 1'b0;
      if (bank_st[i] != BK_IDLE && bank_st[i] != BK_PRECHARGING) any_open = 1'b1;
    end
  end
  // same-bank decoding gated by enable history and device state
  wire logic exec_ok = cke_hh && (dev_q == DV_NORMAL) && !is_nop;
  wire logic do_act = exec_ok && (cmd == CMD_ACT);
  wire logic do_read = exec_ok && (cmd == CMD_READ);
  wire logic do_write = exec_ok && (cmd == CMD_WRITE);
  wire logic do_pre = exec_ok && (cmd == CMD_PRE);
  wire logic do_bst = exec_ok && (cmd == CMD_BST);
  wire logic do_ref = exec_ok && (cmd == CMD_REF) && all_idle;
  wire logic do_mrs = exec_ok && (cmd == CMD_MRS) && all_idle;
  wire logic sr_entry = cke_hl && (dev_q == DV_NORMAL) && !chip_select_n_i &&
    (cmd == CMD_REF) && all_idle;
  wire logic pd_entry = cke_hl && (dev_q == DV_NORMAL) && is_nop;
  // precharge all selected by the auto-precharge address line
  wire logic pre_all = do_pre && auto_pre_i;
  // ************************************
  // bank instances
  // ************************************
  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank
      wire logic hit = (bank_addr_i == BANK_W'(g));
      wire logic stop = do_bst && last_read_valid_q &&
        (last_read_bank_q == BANK_W'(g));
      dbc_bank u_bank (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .act_i(do_act && hit),
        .read_i(do_read && hit),
        .write_i(do_write && hit),
        .pre_i(pre_all || (do_pre && hit)),
        .stop_i(stop),
        .auto_pre_i(auto_pre_i),
        .state_o(bank_st[g])
      );
      assign bank_idle_o[g] = (bank_st[g] == BK_IDLE);
      assign bank_open_o[g] = (bank_st[g] != BK_IDLE) && (bank_st[g] != BK_PRECHARGING);
    end
  endgenerate
  // ************************************
  // device state
  // ************************************
  always_comb begin
    dev_d = dev_q;
    dtmr_d = dev_expired ? TMR_ZERO : dtmr_q - TMR_ONE;
    unique case (dev_q)
      DV_NORMAL: begin
        if (sr_entry) begin
          dev_d = DV_SELF_REFRESH;
        end else if (pd_entry) begin
          dev_d = any_open ? DV_ACTIVE_PD : DV_PRECHARGE_PD;
        end else if (do_ref) begin
          dev_d = DV_REFRESHING;
          dtmr_d = TMR_W'(REFRESH_CYC);
        end else if (do_mrs) begin
          dev_d = DV_MODE_SET;
          dtmr_d = TMR_W'(MODE_SET_CYC);
        end
      end
      DV_REFRESHING, DV_MODE_SET: begin
        if (dev_expired) dev_d = DV_NORMAL;
      end
      DV_PRECHARGE_PD, DV_ACTIVE_PD: begin
        if (cke_lh && is_nop) dev_d = DV_NORMAL;
      end
      DV_SELF_REFRESH: begin
        if (cke_lh && is_nop) begin
          dev_d = DV_SR_EXIT;
          dtmr_d = TMR_W'(SR_EXIT_CYC);
        end
      end
      DV_SR_EXIT: begin
        if (dev_expired) dev_d = DV_NORMAL;
      end
      default: dev_d = DV_NORMAL;
    endcase
  end
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cke_prev_q <= 1'b0;
      dev_q <= DV_NORMAL;
      dtmr_q <= TMR_ZERO;
    end else begin
      cke_prev_q <= clock_enable_i;
      dev_q <= dev_d;
      dtmr_q <= dtmr_d;
    end
  end
  // most recent read burst tracking
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      last_read_valid_q <= 1'b0;
      last_read_bank_q <= BANK_ZERO;
    end else if (do_read && !auto_pre_i) begin
      last_read_valid_q <= 1'b1;
      last_read_bank_q <= bank_addr_i;
    end else if (do_bst || do_pre || do_write || do_act) begin
      last_read_valid_q <= do_act ? last_read_valid_q : 1'b0;
    end
  end
  assign dev_state_o = dev_q;
  assign cmd_ready_o = (dev_q == DV_NORMAL) && cke_prev_q;
endmodule : dbc_top

// >>> test/dbc_top_properties.sv
// dbc_top_properties: concurrent checks on the ports of dbc_top
// assumes a bind onto dbc_top; one clock, synchronous reset
`timescale 1ns/10ps
module dbc_top_properties
  import dbc_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clock_enable_i,
  input wire logic chip_select_n_i,
  input wire logic row_strobe_n_i,
  input wire logic column_strobe_n_i,
  input wire logic write_enable_n_i,
  input wire logic [BANK_W-1:0] bank_addr_i,
  input wire logic auto_pre_i,
  input wire dbc_dev_state_t dev_state_o,
  input wire logic [NUM_BANKS-1:0] bank_idle_o,
  input wire logic [NUM_BANKS-1:0] bank_open_o,
  input wire logic cmd_ready_o
);
  // ****************
  // checks
  // ****************
  wire logic [3:0] cmd = {chip_select_n_i, row_strobe_n_i, column_strobe_n_i, write_enable_n_i};
  wire logic nop = chip_select_n_i || (cmd == CMD_NOP);
  wire logic go = cmd_ready_o && clock_enable_i;
  wire logic b0 = (bank_addr_i == BANK_ZERO);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  AST_ACT_OPENS:
    assert property (go && cmd == CMD_ACT && b0 && bank_idle_o[0]
      |=> (!bank_idle_o[0] && bank_open_o[0]) [*2]) else $error("bank 0 not opened");
  AST_NOP_KEEPS_IDLE:
    assert property (go && nop |=> (bank_idle_o & $past(bank_idle_o)) == $past(bank_idle_o))
      else $error("idle bank left idle on nop");
  AST_PRE_CLOSES:
    assert property (go && cmd == CMD_PRE && b0 && !auto_pre_i && bank_open_o[0]
      |=> !bank_open_o[0] ##[1:3] bank_idle_o[0]) else $error("bank 0 precharge wrong");
  AST_REF_LEN:
    assert property (go && cmd == CMD_REF && &bank_idle_o |=> (dev_state_o == DV_REFRESHING) [*7]
      ##[1:2] dev_state_o == DV_NORMAL) else $error("refresh length wrong");
  AST_PD_ENTRY:
    assert property (cmd_ready_o && !clock_enable_i && nop |=> dev_state_o ==
      ($past(&bank_idle_o) ? DV_PRECHARGE_PD : DV_ACTIVE_PD)) else $error("power-down entry");
  AST_PD_EXIT:
    assert property ((dev_state_o == DV_PRECHARGE_PD || dev_state_o == DV_ACTIVE_PD)
      && clock_enable_i && nop |=> dev_state_o == DV_NORMAL && cmd_ready_o)
      else $error("power-down exit");
  AST_PD_FREEZES:
    assert property (dev_state_o inside {DV_PRECHARGE_PD, DV_ACTIVE_PD, DV_SELF_REFRESH}
      |=> $stable(bank_idle_o) && $stable(bank_open_o)) else $error("bank moved while asleep");
  AST_SR_ENTRY:
    assert property (cmd_ready_o && !clock_enable_i && cmd == CMD_REF && &bank_idle_o
      |=> dev_state_o == DV_SELF_REFRESH) else $error("self refresh entry");
  AST_SR_EXIT_BLOCKS:
    assert property (dev_state_o == DV_SR_EXIT |-> !cmd_ready_o) else $error("ready in exit");
  COV_REF: cover property (go && cmd == CMD_REF);
  COV_PD: cover property (dev_state_o == DV_ACTIVE_PD);
  COV_SR: cover property (dev_state_o == DV_SR_EXIT);
endmodule : dbc_top_properties

// >>> test/dbc_ctrl_model.sv
// dbc_ctrl_model: memory controller model driving the command pins
// assumes requests posted on rising edges; pins change on falling edges
`timescale 1ns/10ps
module dbc_ctrl_model
  import dbc_pkg::*;
(
  input wire logic clock_i,
  input wire logic [3:0] req_cmd_i,
  input wire logic [BANK_W-1:0] req_bank_i,
  input wire logic req_ap_i,
  input wire logic req_cke_i,
  output logic clock_enable_o,
  output logic chip_select_n_o,
  output logic row_strobe_n_o,
  output logic column_strobe_n_o,
  output logic write_enable_n_o,
  output logic [BANK_W-1:0] bank_addr_o,
  output logic auto_pre_o
);
  // ****************
  // pin driver
  // ****************
  initial begin
    clock_enable_o = 1'b0;
    {chip_select_n_o, row_strobe_n_o, column_strobe_n_o, write_enable_n_o} = CMD_NOP;
    bank_addr_o = BANK_ZERO;
    auto_pre_o = 1'b0;
  end
  // requests are posted as given, legal or not; unused address lines toggle
  always @(negedge clock_i) begin
    clock_enable_o <= req_cke_i;
    {chip_select_n_o, row_strobe_n_o, column_strobe_n_o, write_enable_n_o} <= req_cmd_i;
    bank_addr_o <= (req_cmd_i == CMD_NOP) ? ~bank_addr_o : req_bank_i;
    auto_pre_o <= (req_cmd_i == CMD_NOP) ? ~auto_pre_o : req_ap_i;
  end
endmodule : dbc_ctrl_model

// >>> test/dbc_top_tb.sv
// dbc_top_tb: directed scenarios for dbc_top through a controller model
// assumes dbc_pkg timing figures; pins change on falling edges
`timescale 1ns/10ps
module dbc_top_tb
  import dbc_pkg::*;
;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] req_cmd = CMD_NOP;
  logic [BANK_W-1:0] req_bank = BANK_ZERO;
  logic req_ap = 1'b0;
  logic req_cke = 1'b0;
  logic ke, cs_n, ras_n, cas_n, we_n, ap, ready;
  logic [BANK_W-1:0] ba;
  logic [NUM_BANKS-1:0] idle, open;
  dbc_dev_state_t dev;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  dbc_ctrl_model i_ctrl (.clock_i(clock_i), .req_cmd_i(req_cmd), .req_bank_i(req_bank),
    .req_ap_i(req_ap), .req_cke_i(req_cke), .clock_enable_o(ke), .chip_select_n_o(cs_n),
    .row_strobe_n_o(ras_n), .column_strobe_n_o(cas_n), .write_enable_n_o(we_n),
    .bank_addr_o(ba), .auto_pre_o(ap));
  dbc_top i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clock_enable_i(ke),
    .chip_select_n_i(cs_n), .row_strobe_n_i(ras_n), .column_strobe_n_i(cas_n),
    .write_enable_n_i(we_n), .bank_addr_i(ba), .auto_pre_i(ap), .dev_state_o(dev),
    .bank_idle_o(idle), .bank_open_o(open), .cmd_ready_o(ready));
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic ok);
    comparisons++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: check %0d failed", $time, comparisons);
    end
  endtask : chk
  task automatic op(input logic [3:0] c, input logic [BANK_W-1:0] b, input logic a, input logic k);
    @(posedge clock_i);
    req_cmd <= c;
    req_bank <= b;
    req_ap <= a;
    req_cke <= k;
    @(posedge clock_i);
    req_cmd <= CMD_NOP;
    @(negedge clock_i);
  endtask : op
  task automatic nops(input int n);
    repeat (n) @(negedge clock_i);
  endtask : nops
  task automatic t_read_write;
    op(CMD_ACT, 2'h0, 1'b0, 1'b1);
    chk(open[0] === 1'b1 && idle[0] === 1'b0);
    nops(2);
    op(CMD_READ, 2'h0, 1'b0, 1'b1);
    op(CMD_READ, 2'h0, 1'b0, 1'b1);
    op(CMD_BST, 2'h0, 1'b0, 1'b1);
    op(CMD_WRITE, 2'h0, 1'b0, 1'b1);
    op(CMD_READ, 2'h0, 1'b0, 1'b1);
    op(CMD_PRE, 2'h0, 1'b0, 1'b1);
    chk(open[0] === 1'b0 && idle[0] === 1'b0);
    nops(3);
    chk(idle[0] === 1'b1);
  endtask : t_read_write
  task automatic t_auto_pre;
    logic [BANK_W-1:0] b;
    for (int i = 0; i < 2; i++) begin
      b = (i == 0) ? 2'h2 : 2'h3;
      op(CMD_ACT, b, 1'b0, 1'b1);
      nops(2);
      op((i == 0) ? CMD_READ : CMD_WRITE, b, 1'b1, 1'b1);
      nops(4);
      chk(idle[b] === 1'b0);
      nops(4);
      chk(idle[b] === 1'b1 && open[b] === 1'b0);
    end
  endtask : t_auto_pre
  task automatic t_pre_all;
    op(CMD_ACT, 2'h0, 1'b0, 1'b1);
    op(CMD_ACT, 2'h3, 1'b0, 1'b1);
    nops(2);
    op(CMD_PRE, 2'h1, 1'b1, 1'b1);
    chk(open === 4'h0);
    nops(3);
    chk(idle === 4'hF);
  endtask : t_pre_all
  task automatic t_ref_mode;
    op(CMD_REF, 2'h0, 1'b0, 1'b1);
    chk(dev === DV_REFRESHING);
    nops(9);
    chk(dev === DV_NORMAL);
    op(CMD_MRS, 2'h0, 1'b0, 1'b1);
    chk(dev === DV_MODE_SET);
    nops(3);
    chk(dev === DV_NORMAL && idle === 4'hF);
  endtask : t_ref_mode
  task automatic t_power;
    op(CMD_NOP, 2'h0, 1'b0, 1'b0);
    chk(dev === DV_PRECHARGE_PD);
    op(CMD_ACT, 2'h0, 1'b0, 1'b0);
    chk(dev === DV_PRECHARGE_PD && idle[0] === 1'b1);
    op(CMD_NOP, 2'h0, 1'b0, 1'b1);
    chk(dev === DV_NORMAL && ready === 1'b1);
    op(CMD_ACT, 2'h0, 1'b0, 1'b1);
    nops(2);
    op(CMD_NOP, 2'h0, 1'b0, 1'b0);
    chk(dev === DV_ACTIVE_PD && open[0] === 1'b1);
    op(CMD_NOP, 2'h0, 1'b0, 1'b1);
    op(CMD_PRE, 2'h0, 1'b0, 1'b1);
    nops(3);
    chk(idle === 4'hF);
  endtask : t_power
  task automatic t_self_ref;
    op(CMD_REF, 2'h0, 1'b0, 1'b0);
    chk(dev === DV_SELF_REFRESH);
    nops(3);
    op(CMD_NOP, 2'h0, 1'b0, 1'b1);
    chk(dev !== DV_NORMAL && ready === 1'b0);
    nops(SR_EXIT_CYC + 1);
    chk(dev === DV_NORMAL && ready === 1'b1);
    nops(200);
    op(CMD_ACT, 2'h1, 1'b0, 1'b1);
    chk(open[1] === 1'b1);
  endtask : t_self_ref
  task automatic close_out;
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  // ****************
  // sequence
  // ****************
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(negedge clock_i);
    sys_rst_i = 1'b0;
    @(posedge clock_i);
    req_cke <= 1'b1;
    nops(3);
    t_read_write();
    t_auto_pre();
    t_pre_all();
    t_ref_mode();
    t_power();
    t_self_ref();
    close_out();
  end
endmodule : dbc_top_tb
bind dbc_top dbc_top_properties i_props (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .clock_enable_i(clock_enable_i), .chip_select_n_i(chip_select_n_i),
  .row_strobe_n_i(row_strobe_n_i), .column_strobe_n_i(column_strobe_n_i),
  .write_enable_n_i(write_enable_n_i), .bank_addr_i(bank_addr_i), .auto_pre_i(auto_pre_i),
  .dev_state_o(dev_state_o), .bank_idle_o(bank_idle_o), .bank_open_o(bank_open_o),
  .cmd_ready_o(cmd_ready_o));
